// ### supply_guard_consts.svh
// supply_guard_consts.svh: offsets, field positions, reset values and codes
// assumes: included by the supply guard module and by its testbench
`ifndef SUPPLY_GUARD_CONSTS_SVH
`define SUPPLY_GUARD_CONSTS_SVH

// register indices (byte address = 4 * index)
`define IDX_SYS_CTRL       10'h0ff
`define IDX_OSC_CTRL       10'h1e0
`define IDX_VDET_CTRL      10'h1e3
`define IDX_VCMP_STAT      10'h1e4
`define IDX_DUTY_TRIM      10'h1eb
`define IDX_CPU_FLAGS      10'h0f7
`define IDX_IRQ_STATUS     10'h0d0
`define IDX_IRQ_MASK       10'h0d1
`define IDX_EXT_LIMIT      10'h0ff

// system_control_status fields
`define SCS_IRQSTATE_BIT   7
`define SCS_WDOG_BIT       5
`define SCS_POR_BIT        4
`define SCS_SLEEP_BIT      3
`define SCS_STOP_BIT       0
`define SCS_RESET          8'h10
`define POR_FLAG_RESET     1'b1

// oscillator_control fields
`define OSC_NOBUZZ_BIT     5
`define OSC_TIMER_LSB      3
`define OSC_SPEED_LSB      0

// voltage_detect_control fields
`define VDC_TRIP_LSB       4
`define VDC_THRESH_LSB     0

// voltage_compare_status fields
`define VCS_MONITOR_BIT    1
`define VCS_RESETCMP_BIT   0

// sleep_duty_trim fields
`define DUTY_LSB           6

// cpu flags field
`define FLAGS_EXT_BIT      4
`define FLAGS_GIE_BIT      0

// codes
`define TRIP_DEFAULT       2'h0
`define TRIP_HIGH          2'h2
`define THRESH_TOP_LOW     3'h6
`define SPEED_12M_MAX      3'h3
`define REG_ZERO           8'h00

// interrupt status bits
`define IRQ_LOW_VOLT_BIT   0
`define IRQ_SPEED_BIT      1

`endif

// ### supply_guard_pkg.sv
// supply_guard_pkg.sv: types for the supply guard and speed control block
// assumes: constants come from supply_guard_consts.svh
package supply_guard_pkg;

  // block state, registered as one word
  typedef struct packed {
    logic            ack;
    logic [7:0]      rdat;
    logic            ext_sel;
    logic            gie;
    logic            wdog;
    logic            por_flag;
    logic            sleep;
    logic            stop;
    logic            no_buzz;
    logic [1:0]      sleep_timer;
    logic [2:0]      speed;
    logic [1:0]      trip;
    logic [2:0]      thresh;
    logic [1:0]      duty;
    logic [1:0][2:0] sync;
    logic [1:0]      stable;
    logic [1:0]      irq_stat;
    logic [1:0]      irq_mask;
  } state_t;

  // supply settings presented to the analog side
  typedef struct packed {
    logic [2:0] monitor_threshold_select;
    logic [1:0] reset_trip_level;
    logic [2:0] cpu_speed;
    logic [1:0] sleep_timer;
    logic       no_buzz;
    logic [1:0] sleep_duty;
    logic       sleep;
    logic       stop;
  } supply_cfg_t;

endpackage

// ### supply_guard_speed_control.sv
// supply_guard_speed_control.sv: voltage monitor, reset trip level and cpu speed registers
// assumes: classic wishbone master on clk_i, analog comparators drive async levels
//
// What this block does
// RQ1 - extended registers need extended space select set
// RQ2 - trip field code 10b selects high level
// RQ3 - software raises trip level before fast speed
// RQ4 - trip defaults low; comparator reasserts reset
// RQ5 - 3-bit monitor threshold, eight trip points
// RQ6 - comparator status in bit 1, read-only
// RQ7 - software polls, debounces, raises level, speeds up
// RQ8 - low voltage monitor raises maskable interrupt
// RQ9 - after fallback software restores level then speed
// RQ10 - comparators synchronised before status or interrupt
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`include "supply_guard_consts.svh"

module supply_guard_speed_control
  import supply_guard_pkg::*;
(
  input  wire logic        clk_i,              // cpu clock, 100 mhz
  input  wire logic        rst_i,              // synchronous reset, active high
  input  wire logic        ce_i,               // clock enable, freezes state when low
  input  wire logic [11:0] adr_i,              // wishbone byte address
  input  wire logic [31:0] dat_i,              // wishbone write data
  output logic      [31:0] dat_o,              // wishbone read data
  input  wire logic [3:0]  sel_i,              // wishbone byte selects
  input  wire logic        we_i,               // wishbone write enable
  input  wire logic        cyc_i,              // wishbone cycle
  input  wire logic        stb_i,              // wishbone strobe
  output logic             ack_o,              // wishbone acknowledge
  input  wire logic        monitor_comp_i,     // async monitor comparator, high below trip
  input  wire logic        reset_comp_i,       // async reset comparator, high below level
  input  wire logic        watchdog_reset_i,   // pulse: last reset came from the watchdog
  output supply_cfg_t      cfg_o,              // settings for oscillator and analog side
  output logic             reset_request_o,    // asks the reset generator for reset
  output logic             irq_o               // level interrupt
);

  // all state lives in one registered word; n is its next value.
  // the comparator inputs come straight from analog parts and may
  // change at any time, so they pass a three-stage chain and are only
  // believed once the last two stages agree; a glitch shorter than a
  // clock never reaches the status bit or the interrupt.
  // the device never blocks a fast speed write: software owns the
  // order of trip level and speed, and a wrong order only raises the
  // speed event so that firmware faults are visible.
  state_t q;
  state_t n;

  // register index from a byte address, shared by read and write paths
  function automatic logic [9:0] reg_index(input logic [11:0] adr);
    reg_index = adr[11:2];
  endfunction

  // speed codes above the 12 mhz code count as fast
  function automatic logic is_fast(input logic [2:0] speed);
    is_fast = (speed > `SPEED_12M_MAX);
  endfunction

  // mapped register test, extended space gated by the select bit
  function automatic logic is_mapped(input logic [9:0] idx, input logic ext);
    logic hit;
    hit = (idx == `IDX_SYS_CTRL) || (idx == `IDX_CPU_FLAGS) || (idx == `IDX_IRQ_STATUS) ||
          (idx == `IDX_IRQ_MASK) || (idx == `IDX_OSC_CTRL) || (idx == `IDX_VDET_CTRL) ||
          (idx == `IDX_VCMP_STAT) || (idx == `IDX_DUTY_TRIM);
    // RQ1 extended space gate
    is_mapped = hit && ((idx <= `IDX_EXT_LIMIT) || ext);
  endfunction

  logic [9:0] idx;
  logic       req;
  logic       wr_commit;
  logic       mapped;
  logic [1:0] evt;
  logic [1:0] async_in;

  assign idx      = reg_index(adr_i);
  assign req      = cyc_i && stb_i;
  assign mapped   = is_mapped(idx, q.ext_sel);
  assign async_in = {reset_comp_i, monitor_comp_i};
  // write lands at the edge where the master sees ack
  assign wr_commit = req && q.ack && we_i && sel_i[0] && mapped;

  // next state
  always_comb begin
    n = q;
    evt = 2'h0;
    // single-cycle ack, dropped the cycle after it is given
    n.ack = req && !q.ack;
    // read data captured with the ack
    if (req && !q.ack) begin
      n.rdat = `REG_ZERO;
      if (mapped) begin
        case (idx)
          `IDX_SYS_CTRL: begin
            n.rdat[`SCS_IRQSTATE_BIT] = q.gie;
            n.rdat[`SCS_WDOG_BIT]  = q.wdog;
            n.rdat[`SCS_POR_BIT]   = q.por_flag;
            n.rdat[`SCS_SLEEP_BIT] = q.sleep;
            n.rdat[`SCS_STOP_BIT]  = q.stop;
          end
          `IDX_CPU_FLAGS: begin
            n.rdat[`FLAGS_EXT_BIT] = q.ext_sel;
            n.rdat[`FLAGS_GIE_BIT] = q.gie;
          end
          `IDX_OSC_CTRL: begin
            n.rdat[`OSC_NOBUZZ_BIT]                 = q.no_buzz;
            n.rdat[`OSC_TIMER_LSB +: 2]             = q.sleep_timer;
            n.rdat[`OSC_SPEED_LSB +: 3]             = q.speed;
          end
          `IDX_VDET_CTRL: begin
            n.rdat[`VDC_TRIP_LSB +: 2] = q.trip;
            n.rdat[`VDC_THRESH_LSB +: 3] = q.thresh;
          end
          // RQ6 comparator status, read-only
          `IDX_VCMP_STAT: begin
            n.rdat[`VCS_MONITOR_BIT]  = q.stable[0];
            n.rdat[`VCS_RESETCMP_BIT] = q.stable[1];
          end
          `IDX_DUTY_TRIM: n.rdat[`DUTY_LSB +: 2] = q.duty;
          `IDX_IRQ_STATUS: n.rdat[1:0] = q.irq_stat;
          `IDX_IRQ_MASK: n.rdat[1:0] = q.irq_mask;
          default: n.rdat = `REG_ZERO;
        endcase
      end
    end
    // register writes
    if (wr_commit) begin
      case (idx)
        `IDX_SYS_CTRL: begin
          // flags clear on writing one
          if (dat_i[`SCS_WDOG_BIT]) n.wdog = 1'b0;
          if (dat_i[`SCS_POR_BIT]) n.por_flag = 1'b0;
          n.sleep = dat_i[`SCS_SLEEP_BIT];
          n.stop  = dat_i[`SCS_STOP_BIT];
        end
        `IDX_CPU_FLAGS: begin
          n.ext_sel = dat_i[`FLAGS_EXT_BIT];
          n.gie     = dat_i[`FLAGS_GIE_BIT];
        end
        `IDX_OSC_CTRL: begin
          n.no_buzz     = dat_i[`OSC_NOBUZZ_BIT];
          n.sleep_timer = dat_i[`OSC_TIMER_LSB +: 2];
          n.speed       = dat_i[`OSC_SPEED_LSB +: 3];
        end
        // RQ2 trip field, RQ5 monitor threshold
        `IDX_VDET_CTRL: begin
          n.trip = dat_i[`VDC_TRIP_LSB +: 2];
          n.thresh = dat_i[`VDC_THRESH_LSB +: 3];
        end
        `IDX_DUTY_TRIM: n.duty = dat_i[`DUTY_LSB +: 2];
        `IDX_IRQ_STATUS: n.irq_stat = q.irq_stat & ~dat_i[1:0];
        `IDX_IRQ_MASK: n.irq_mask = dat_i[1:0];
        default: n.ext_sel = q.ext_sel;
      endcase
    end
    // RQ10 three-stage synchronisers, accepted once stages two and three agree
    for (int k = 0; k < 2; k++) begin
      n.sync[k][0] = async_in[k];
      n.sync[k][1] = q.sync[k][0];
      n.sync[k][2] = q.sync[k][1];
      if (q.sync[k][1] == q.sync[k][2]) n.stable[k] = q.sync[k][2];
    end
    // RQ8 low voltage event on the synchronised comparator rising
    evt[`IRQ_LOW_VOLT_BIT] = n.stable[0] && !q.stable[0];
    // RQ2 event when fast speed runs without the high trip level
    evt[`IRQ_SPEED_BIT] = (is_fast(n.speed) && (n.trip != `TRIP_HIGH)) &&
                          !(is_fast(q.speed) && (q.trip != `TRIP_HIGH));
    // set wins over a clear in the same cycle
    n.irq_stat = n.irq_stat | evt;
    if (watchdog_reset_i) n.wdog = 1'b1;
  end

  // state register with clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      // RQ4 low default trip after reset
      q.trip     <= `TRIP_DEFAULT;
      q.por_flag <= `POR_FLAG_RESET;
    end else if (ce_i) begin
      q <= n;
    end
  end

  // outputs
  assign ack_o = q.ack;
  assign dat_o = {24'h000000, q.rdat};
  assign cfg_o = '{monitor_threshold_select: q.thresh, reset_trip_level: q.trip, cpu_speed: q.speed,
                   sleep_timer: q.sleep_timer, no_buzz: q.no_buzz, sleep_duty: q.duty,
                   sleep: q.sleep, stop: q.stop};
  // RQ4 reset follows the synchronised reset comparator
  assign reset_request_o = q.stable[1];
  // RQ8 interrupt while an unmasked status bit is set
  assign irq_o = |(q.irq_stat & q.irq_mask);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic ext_write_blocked;
  assign ext_write_blocked = ce_i && req && q.ack && we_i && sel_i[0] &&
                             (idx == `IDX_VDET_CTRL) && !q.ext_sel;

  sequence monitor_held;
    (ce_i && monitor_comp_i)[*4];
  endsequence

  sequence reset_cmp_held;
    (ce_i && reset_comp_i)[*4];
  endsequence

  a_ack_one_cycle: assert property (ce_i && ack_o |=> !ack_o) // RQ1
    else $error("ack held longer than one cycle");

  a_ext_space_gate: assert property (ext_write_blocked |=> $stable(cfg_o.reset_trip_level) && // RQ1
                                     $stable(cfg_o.monitor_threshold_select))
    else $error("extended register written while space select clear");

  a_trip_reset_low: assert property ($past(rst_i) |-> cfg_o.reset_trip_level == 2'h0) // RQ4
    else $error("trip level not low after reset");

  a_reset_follow: assert property (reset_cmp_held |=> reset_request_o) // RQ4
    else $error("reset comparator did not request reset");

  a_thresh_write_lands: assert property (ce_i && wr_commit && idx == `IDX_VDET_CTRL |=> // RQ5
                                     cfg_o.monitor_threshold_select == $past(dat_i[2:0]))
    else $error("monitor threshold not written");

  a_monitor_sync: assert property (monitor_held |=> q.stable[0]) // RQ10
    else $error("monitor comparator not taken after sync");

  a_status_clear: assert property (ce_i && !monitor_comp_i ##1 (ce_i && !monitor_comp_i)[*3] // RQ6
                                   |=> !q.stable[0])
    else $error("comparator status not clear above trip");

  a_irq_raise: assert property (ce_i && !q.stable[0] && n.stable[0] && q.irq_mask[0] |=> irq_o) // RQ8
    else $error("low voltage event did not interrupt");

  a_speed_guard: assert property (ce_i && is_fast(n.speed) && n.trip != 2'h2 && // RQ2
                                  !(is_fast(q.speed) && q.trip != 2'h2) |=> q.irq_stat[1])
    else $error("fast speed without high trip not flagged");

  // a request taken while the bus is idle
  sequence bus_taken;
    ce_i && req && !ack_o;
  endsequence

  // the edge at which the master sees the answer
  sequence bus_answered;
    ce_i && req && ack_o;
  endsequence

  // reset comparator clear for four enabled samples
  sequence reset_cmp_clear;
    (ce_i && !reset_comp_i)[*4];
  endsequence

  // RQ1 answer follows take
  a_ack_follows: assert property (bus_taken |=> ack_o) // RQ1
    else $error("request not acknowledged");

  // RQ1 ack dropped after answer
  a_ack_gap: assert property (bus_answered |=> !ack_o) // RQ1
    else $error("ack not dropped after answer");

  // RQ1 upper lanes zero
  a_upper_lanes: assert property (ack_o |-> dat_o[31:8] == 24'h000000) // RQ1
    else $error("upper read lanes not zero");

  // read of an extended register while the space select is clear
  logic ext_read_blocked;
  assign ext_read_blocked = ce_i && req && !q.ack && !we_i &&
                            (idx == `IDX_VDET_CTRL) && !q.ext_sel;

  // RQ1 blocked read zero
  a_ext_read_zero: assert property (ext_read_blocked |=> dat_o == 32'h00000000) // RQ1
    else $error("extended register readable while space select clear");

  // RQ2 trip write lands
  a_trip_write_lands: assert property (ce_i && wr_commit && idx == `IDX_VDET_CTRL |=> // RQ2
                                       cfg_o.reset_trip_level == $past(dat_i[5:4]))
    else $error("reset trip level not written");

  // RQ2 speed write lands
  a_speed_write_lands: assert property (ce_i && wr_commit && idx == `IDX_OSC_CTRL |=> // RQ2
                                        cfg_o.cpu_speed == $past(dat_i[2:0]))
    else $error("cpu speed not written");

  // RQ2 high trip keeps quiet
  a_speed_quiet: assert property (ce_i && is_fast(n.speed) && n.trip == 2'h2 && !q.irq_stat[1] |=> // RQ2
                                  !q.irq_stat[1])
    else $error("speed event raised with high trip level");

  // RQ4 reset request released
  a_reset_release: assert property (reset_cmp_clear |=> !reset_request_o) // RQ4
    else $error("reset request held with comparator clear");

  // RQ4 power flag set after reset
  a_por_after_reset: assert property ($past(rst_i) |-> q.por_flag) // RQ4
    else $error("power on reset flag not set after reset");

  // RQ4 watchdog pulse recorded
  a_wdog_set: assert property (ce_i && watchdog_reset_i |=> q.wdog) // RQ4
    else $error("watchdog reset not recorded");

  // RQ6 status read returns comparator
  a_cmp_readback: assert property (ce_i && req && !q.ack && !we_i && q.ext_sel && // RQ6
                                   idx == `IDX_VCMP_STAT |=> dat_o[1] == $past(q.stable[0]))
    else $error("comparator status read wrong");

  // RQ8 low voltage event recorded even when masked
  a_low_event: assert property (ce_i && !q.stable[0] && n.stable[0] |=> q.irq_stat[0]) // RQ8
    else $error("low voltage event not recorded");

  // RQ8 status bit sticky
  a_status_sticky: assert property (ce_i && q.irq_stat[0] && // RQ8
                                    !(wr_commit && idx == `IDX_IRQ_STATUS && dat_i[0]) |=> q.irq_stat[0])
    else $error("status bit lost without a clear");

  // RQ8 write one clears
  a_status_w1c: assert property (ce_i && wr_commit && idx == `IDX_IRQ_STATUS && dat_i[0] && // RQ8
                                 !evt[0] |=> !q.irq_stat[0])
    else $error("status bit not cleared by written one");

  // RQ8 masked events stay silent
  a_irq_masked: assert property (ce_i && !q.irq_mask[0] && !q.irq_mask[1] && // RQ8
                                 !(wr_commit && idx == `IDX_IRQ_MASK) |=> !irq_o)
    else $error("interrupt raised while all events masked");

  // RQ10 enable low freezes state
  a_ce_freeze: assert property (!ce_i |=> $stable(q)) // RQ10
    else $error("state moved while clock enable low");

endmodule

// ### supply_guard_speed_control_tb.sv
// supply_guard_speed_control_tb.sv: self-checking bench for the supply guard block
// assumes: design files compiled first; wishbone driven here, comparators driven as plain levels
`timescale 1ns/1ps
`include "supply_guard_consts.svh"
module supply_guard_speed_control_tb
  import supply_guard_pkg::*;
;
  logic        clk_i, rst_i, ce_i, we_i, cyc_i, stb_i, ack_o, irq_o;
  logic        monitor_comp_i, reset_comp_i, watchdog_reset_i, reset_request_o;
  logic [11:0] adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  sel_i;
  supply_cfg_t cfg_o;
  logic [7:0]  d;
  int          mismatches, checked, i;

  supply_guard_speed_control DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .monitor_comp_i(monitor_comp_i), .reset_comp_i(reset_comp_i), .watchdog_reset_i(watchdog_reset_i),
    .cfg_o(cfg_o), .reset_request_o(reset_request_o), .irq_o(irq_o));

  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // expected readback of the monitor control word
  function automatic logic [7:0] vdc_exp(input logic [7:0] v);
    return {2'h0, v[5:4], 1'b0, v[2:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] v, output logic [31:0] r);
    int n;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= {idx, 2'h0}; dat_i <= {24'h0, v}; sel_i <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    r = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] v);
    logic [31:0] r;
    wb(1'b1, idx, v, r);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    wb(1'b0, idx, 8'h00, r);
    check(r, {24'h0, exp});
  endtask

  // poll the monitor bit until clear, then read it twice more as debounce
  task automatic wait_supply_ok();
    logic [31:0] r;
    i = 0;
    do begin
      wb(1'b0, `IDX_VCMP_STAT, 8'h00, r);
      i++;
    end while (r[1] !== 1'b0 && i < 20);
    rd(`IDX_VCMP_STAT, 8'h00);
    rd(`IDX_VCMP_STAT, 8'h00);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    mismatches = 0; checked = 0; i = $urandom(13);
    rst_i = 1'b1; ce_i = 1'b1; adr_i = '0; dat_i = '0; sel_i = '0; we_i = 1'b0; cyc_i = 1'b0; stb_i = 1'b0;
    monitor_comp_i = 1'b0; reset_comp_i = 1'b0; watchdog_reset_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(cfg_o, '0);
    rd(`IDX_SYS_CTRL, `SCS_RESET);
    // extended space closed: write dropped, read zero
    wr(`IDX_VDET_CTRL, 8'h26);
    rd(`IDX_VDET_CTRL, 8'h00);
    check(cfg_o.reset_trip_level, 2'h0);
    rd(10'h0a0, 8'h00);
    wr(`IDX_CPU_FLAGS, 8'h10);
    rd(`IDX_VDET_CTRL, 8'h00);
    // every threshold code with random other bits
    for (int v = 0; v < 8; v++) begin
      d = $urandom;
      d[2:0] = v;
      wr(`IDX_VDET_CTRL, d);
      rd(`IDX_VDET_CTRL, vdc_exp(d));
      check(cfg_o.monitor_threshold_select, v[2:0]);
    end
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      wr(`IDX_DUTY_TRIM, d);
      rd(`IDX_DUTY_TRIM, d & 8'hc0);
      check(cfg_o.sleep_duty, d[7:6]);
    end
    // watchdog flag sets and clears on a written one
    watchdog_reset_i <= 1'b1;
    @(posedge clk_i);
    watchdog_reset_i <= 1'b0;
    rd(`IDX_SYS_CTRL, 8'h30);
    wr(`IDX_SYS_CTRL, 8'h30);
    rd(`IDX_SYS_CTRL, 8'h00);
    // fast speed with low trip level raises the speed event, masked first
    wr(`IDX_VDET_CTRL, 8'h06);
    wr(`IDX_IRQ_STATUS, 8'h03);
    wr(`IDX_OSC_CTRL, 8'h3c);
    rd(`IDX_OSC_CTRL, 8'h3c);
    rd(`IDX_IRQ_STATUS, 8'h02);
    check(irq_o, 1'b0);
    wr(`IDX_IRQ_MASK, 8'h02);
    check(irq_o, 1'b1);
    wr(`IDX_IRQ_STATUS, 8'h02);
    check(irq_o, 1'b0);
    wr(`IDX_OSC_CTRL, 8'h03);
    // reset comparator: latency of the synchroniser
    reset_comp_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(reset_request_o, 1'b0);
    repeat (4) @(posedge clk_i);
    check(reset_request_o, 1'b1);
    reset_comp_i <= 1'b0;
    // supply sags: monitor bit, read-only status, interrupt
    wr(`IDX_IRQ_MASK, 8'h03);
    monitor_comp_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    repeat (6) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd(`IDX_VCMP_STAT, 8'h02);
    wr(`IDX_VCMP_STAT, 8'h00);
    rd(`IDX_VCMP_STAT, 8'h02);
    // handler: drop speed, lower trip, clear the event
    wr(`IDX_OSC_CTRL, 8'h03);
    wr(`IDX_VDET_CTRL, 8'h06);
    wr(`IDX_IRQ_STATUS, 8'h01);
    check(irq_o, 1'b0);
    monitor_comp_i <= 1'b0;
    // recovery: poll, debounce, high trip, then fast speed
    wait_supply_ok();
    wr(`IDX_VDET_CTRL, 8'h26);
    check(cfg_o.reset_trip_level, `TRIP_HIGH);
    wr(`IDX_OSC_CTRL, 8'h04);
    check(cfg_o.cpu_speed, 3'h4);
    rd(`IDX_IRQ_STATUS, 8'h00);
    check(irq_o, 1'b0);
    // clock enable low: a watchdog pulse must not land
    ce_i <= 1'b0;
    watchdog_reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    watchdog_reset_i <= 1'b0;
    @(posedge clk_i);
    rd(`IDX_SYS_CTRL, 8'h00);
    check(cfg_o.cpu_speed, 3'h4);
    // second reset in mid-run
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(cfg_o, '0);
    check(reset_request_o, 1'b0);
    rd(`IDX_SYS_CTRL, `SCS_RESET);
    conclude();
  end
endmodule
